// ### spd_decoder.sv
// Serial programming command decoder with program and data arrays
`timescale 1ns/100ps
// What this block does
// - Programming is accepted only after the enable command AC 53 xx xx while reset is low.
// - Command AC with second byte 100xxxxx erases program and data arrays.
// - Command 0010H000 returns the chosen byte of the addressed program word in byte four.
// - Command 0100H000 writes byte four into the chosen half of the program word.
// - The program word address is second byte bits 3..0 joined to the third byte.
// - Command A0 returns the data byte at address second byte bit 0 joined to third byte.
// - Command C0 writes byte four to the data array at that address.
// - Command AC with second byte 111xxxxx writes lock bits 2 and 1 from bits 2 and 1.
// - Command 30 returns the signature byte picked by third byte bits 1..0.
// - Bits marked don't care never influence decoding.
module spd_decoder
  import spd_pkg::*;
(
  input  wire logic       CLK_IN,
  input  wire logic       SYS_RST_IN,
  input  wire logic       PROG_RESET_N_IN,
  input  wire logic       SCK_IN,
  input  wire logic       MOSI_IN,
  output logic            MISO_OUT,
  output logic            PROG_ENABLED_OUT,
  output logic [1:0]      LOCK_BITS_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Three-stage samplers; change counts when stages two and three agree
  logic [2:0] rst_s;
  logic [2:0] sck_s;
  logic [2:0] mosi_s;
  logic       rst_q;
  logic       sck_q;
  logic       mosi_q;

  always_ff @(posedge CLK_IN) begin
    rst_s  <= {rst_s[1:0], PROG_RESET_N_IN};
    sck_s  <= {sck_s[1:0], SCK_IN};
    mosi_s <= {mosi_s[1:0], MOSI_IN};
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      rst_q  <= 1'b1;
      sck_q  <= 1'b0;
      mosi_q <= 1'b0;
    end else begin
      if (rst_s[1] == rst_s[2]) rst_q <= rst_s[2];
      if (sck_s[1] == sck_s[2]) sck_q <= sck_s[2];
      if (mosi_s[1] == mosi_s[2]) mosi_q <= mosi_s[2];
    end
  end

  logic sck_rise;
  logic sck_fall;
  assign sck_rise = (sck_s[1] == sck_s[2]) && sck_s[2] && !sck_q;
  assign sck_fall = (sck_s[1] == sck_s[2]) && !sck_s[2] && sck_q;

  ////////////////////////////////////////////////////////////////////////////
  // Shift register; MSB first, sampled on rising SCK
  logic [31:0] cmd;
  logic [4:0]  bit_cnt;
  logic        cmd_done;

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN || rst_q) begin
      cmd      <= 32'h0;
      bit_cnt  <= 5'h0;
      cmd_done <= 1'b0;
    end else begin
      cmd_done <= 1'b0;
      if (sck_rise) begin
        cmd     <= {cmd[30:0], mosi_q};
        bit_cnt <= bit_cnt + 5'h1;
        cmd_done <= (bit_cnt == SPD_BITS_PER_CMD);
      end
    end
  end

  // Command fields, only defined bits looked at
  logic [7:0]  op;
  logic [7:0]  b2;
  logic [7:0]  b3;
  logic [7:0]  b4;
  logic        is_ac;
  assign op    = cmd[31:24];
  assign b2    = cmd[23:16];
  assign b3    = cmd[15:8];
  assign b4    = cmd[7:0];
  assign is_ac = (op == SPD_OP_ENABLE);

  // Live view of bytes 1..3 during byte four
  logic [7:0] live_op;
  logic [11:0] live_paddr;
  logic [8:0]  live_eaddr;
  assign live_op    = cmd[23:16];
  assign live_paddr = {cmd[11:8], cmd[7:0]};
  assign live_eaddr = {cmd[8], cmd[7:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Enable state
  logic enabled;

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN || rst_q) begin
      enabled <= 1'b0;
    end else if (cmd_done && is_ac && b2 == SPD_ENABLE_B2) begin
      enabled <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arrays; erase walks both arrays, one location per clock
  logic [7:0]  prog_hi [SPD_PROG_WORDS];
  logic [7:0]  prog_lo [SPD_PROG_WORDS];
  logic [7:0]  ee_mem  [SPD_EE_BYTES];
  logic        erasing;
  logic [11:0] erase_addr;
  logic [1:0]  lock;

  // Word opcodes carry the byte select in one bit, so it is masked off
  function automatic logic word_op(input logic [7:0] code, input logic [7:0] base);
    word_op = ((code & SPD_OP_MASK_H) == base);
  endfunction

  logic wr_prog;
  logic wr_ee;
  logic do_erase;
  logic do_lock;
  assign wr_prog  = cmd_done && enabled && word_op(op, SPD_OP_WR_PROG);
  assign wr_ee    = cmd_done && enabled && (op == SPD_OP_WR_EE);
  assign do_erase = cmd_done && enabled && is_ac && (b2[7:5] == SPD_ERASE_TAG);
  assign do_lock  = cmd_done && enabled && is_ac && (b2[7:5] == SPD_LOCK_TAG);

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      erasing    <= 1'b0;
      erase_addr <= 12'h0;
    end else if (do_erase) begin
      erasing    <= 1'b1;
      erase_addr <= 12'h0;
    end else if (erasing) begin
      erase_addr <= erase_addr + 12'h1;
      if (erase_addr == 12'(SPD_PROG_WORDS - 1)) erasing <= 1'b0;
    end
  end

  // Memories are not reset; only erase or writes change them
  always_ff @(posedge CLK_IN) begin
    if (erasing) begin
      prog_hi[erase_addr] <= SPD_ERASED_BYTE;
      prog_lo[erase_addr] <= SPD_ERASED_BYTE;
      if (erase_addr < 12'(SPD_EE_BYTES)) ee_mem[erase_addr[8:0]] <= SPD_ERASED_BYTE;
    end else if (wr_prog) begin
      if (op[SPD_H_BIT]) prog_hi[{b2[3:0], b3}] <= b4;
      else prog_lo[{b2[3:0], b3}] <= b4;
    end else if (wr_ee) begin
      ee_mem[{b2[0], b3}] <= b4;
    end
  end

  // Lock bits: zero programs; erase releases them
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN || (do_erase)) begin
      lock <= SPD_LOCK_RESET;
    end else if (do_lock) begin
      lock <= lock & b2[2:1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data: loaded after bit 24, shifted out on falling SCK
  function automatic logic [7:0] sig_byte(input logic [1:0] sel);
    case (sel)
      2'h0:    sig_byte = SPD_SIG0;
      2'h1:    sig_byte = SPD_SIG1;
      2'h2:    sig_byte = SPD_SIG2;
      default: sig_byte = SPD_SIG3;
    endcase
  endfunction

  logic [7:0] rd_data;
  always_comb begin
    rd_data = 8'h0;
    if (word_op(live_op, SPD_OP_RD_PROG)) begin
      rd_data = live_op[SPD_H_BIT] ? prog_hi[live_paddr] : prog_lo[live_paddr];
    end else if (live_op == SPD_OP_RD_EE) begin
      rd_data = ee_mem[live_eaddr];
    end else if (live_op == SPD_OP_RD_SIG) begin
      rd_data = sig_byte(cmd[1:0]);
    end
  end

  logic [7:0] out_sr;
  logic       load_pend;

  // Loading one fall after bit 24 keeps the first bit valid before rise 25
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN || rst_q) begin
      out_sr    <= 8'h0;
      load_pend <= 1'b0;
      MISO_OUT  <= 1'b0;
    end else begin
      if (sck_rise && bit_cnt == (SPD_BITS_PER_CMD - 5'h8)) load_pend <= enabled;
      if (sck_fall) begin
        if (load_pend) begin
          MISO_OUT  <= rd_data[7];
          out_sr    <= {rd_data[6:0], 1'b0};
          load_pend <= 1'b0;
        end else begin
          MISO_OUT <= out_sr[7];
          out_sr   <= {out_sr[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      PROG_ENABLED_OUT <= 1'b0;
      LOCK_BITS_OUT    <= SPD_LOCK_RESET;
    end else begin
      PROG_ENABLED_OUT <= enabled;
      LOCK_BITS_OUT    <= lock;
    end
  end

endmodule

// ### spd_pkg.sv
// Constants for the serial programming command decoder
package spd_pkg;
  localparam logic [7:0] SPD_OP_ENABLE    = 8'hAC;
  localparam logic [7:0] SPD_ENABLE_B2    = 8'h53;
  localparam logic [7:0] SPD_OP_RD_PROG   = 8'h20;
  localparam logic [7:0] SPD_OP_WR_PROG   = 8'h40;
  localparam logic [7:0] SPD_OP_RD_EE     = 8'hA0;
  localparam logic [7:0] SPD_OP_WR_EE     = 8'hC0;
  localparam logic [7:0] SPD_OP_RD_SIG    = 8'h30;
  localparam logic [7:0] SPD_OP_MASK_H    = 8'hF7;
  localparam logic [2:0] SPD_ERASE_TAG    = 3'h4;
  localparam logic [2:0] SPD_LOCK_TAG     = 3'h7;
  localparam int         SPD_H_BIT        = 3;
  localparam int         SPD_PROG_WORDS   = 4096;
  localparam int         SPD_EE_BYTES     = 512;
  localparam logic [4:0] SPD_BITS_PER_CMD = 5'h1F;
  localparam logic [1:0] SPD_LOCK_RESET   = 2'h3;
  localparam logic [7:0] SPD_ERASED_BYTE  = 8'hFF;
  localparam logic [7:0] SPD_SIG0         = 8'h1E; // Arbitrary value
  localparam logic [7:0] SPD_SIG1         = 8'h5A; // Arbitrary value
  localparam logic [7:0] SPD_SIG2         = 8'h3C; // Arbitrary value
  localparam logic [7:0] SPD_SIG3         = 8'h00; // Arbitrary value
endpackage

// ### spd_decoder_sva.sv
// Checker for the serial programming command decoder
`timescale 1ns/100ps
module spd_decoder_sva
  import spd_pkg::*;
(
  input wire logic       CLK_IN,
  input wire logic       SYS_RST_IN,
  input wire logic       PROG_RESET_N_IN,
  input wire logic       SCK_IN,
  input wire logic       MOSI_IN,
  input wire logic       MISO_OUT,
  input wire logic       PROG_ENABLED_OUT,
  input wire logic [1:0] LOCK_BITS_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  a_reset_clears: assert property (disable iff (1'b0) SYS_RST_IN |=>
    !PROG_ENABLED_OUT && !MISO_OUT && LOCK_BITS_OUT == SPD_LOCK_RESET) else $error("reset");
  a_pin_blocks_on: assert property (PROG_RESET_N_IN [*8] |-> !PROG_ENABLED_OUT)
    else $error("enabled with pin high");
  a_enable_pin_low: assert property ($rose(PROG_ENABLED_OUT) |-> !PROG_RESET_N_IN
    && LOCK_BITS_OUT == $past(LOCK_BITS_OUT)) else $error("bad enable");
  a_enable_falls_pin: assert property ($fell(PROG_ENABLED_OUT) |-> PROG_RESET_N_IN)
    else $error("enable lost");
  a_refused_quiet: assert property (!PROG_ENABLED_OUT [*4] |-> !MISO_OUT)
    else $error("data while refused");
  a_lock_while_on: assert property ($changed(LOCK_BITS_OUT) |-> PROG_ENABLED_OUT)
    else $error("lock moved while off");
  a_idle_keeps_on: assert property (disable iff (SYS_RST_IN || PROG_RESET_N_IN)
    !SCK_IN [*8] |=> $stable(PROG_ENABLED_OUT)) else $error("enable moved idle");
  a_idle_keeps_miso: assert property (disable iff (SYS_RST_IN || PROG_RESET_N_IN)
    !SCK_IN [*8] |=> $stable(MISO_OUT)) else $error("data moved idle");
endmodule
bind spd_decoder spd_decoder_sva chk_u (.*);

// ### spd_prog_model.sv
// Programmer model that shifts instructions in and read data out
`timescale 1ns/100ps
module spd_prog_model (
  output logic      sck_out,
  output logic      mosi_out,
  input  wire logic miso_in
);
  initial begin
    sck_out = 1'b0;
    mosi_out = 1'b0;
  end
  // Clock stands low between frames; idle data flips so a stale bit never looks valid
  task automatic xfer(input logic [31:0] cmd, output logic [7:0] rd);
    for (int i = 31; i >= 0; i--) begin
      #50 mosi_out = cmd[i];
      #50 sck_out = 1'b1;
      #100 if (i < 8) rd[i] = miso_in;
      sck_out = 1'b0;
    end
    #50 mosi_out = ~mosi_out;
    #150;
  endtask
endmodule

// ### testbench.sv
// Testbench for the serial programming command decoder
`timescale 1ns/100ps
module testbench;
  import spd_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       pin_n = 1'b0;
  logic       sck, mosi, miso, on;
  logic [1:0] lock;
  logic [7:0] rd;
  logic [7:0] sig [4] = '{SPD_SIG0, SPD_SIG1, SPD_SIG2, SPD_SIG3};
  int         fail_count = 0;
  int         check_count = 0;
  initial begin
    forever #12.5 clk = ~clk;
  end
  spd_decoder dut_u (.CLK_IN(clk), .SYS_RST_IN(rst), .PROG_RESET_N_IN(pin_n), .SCK_IN(sck),
    .MOSI_IN(mosi), .MISO_OUT(miso), .PROG_ENABLED_OUT(on), .LOCK_BITS_OUT(lock));
  spd_prog_model prog_u (.sck_out(sck), .mosi_out(mosi), .miso_in(miso));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic t_enable();
    chk({5'h0, miso, on, lock}, 8'h03);
    prog_u.xfer({SPD_OP_RD_SIG, 24'h0}, rd);
    chk(rd, 8'h00);
    prog_u.xfer({SPD_OP_ENABLE, SPD_ENABLE_B2, 16'hA55A}, rd);
    chk({7'h0, on}, 8'h01);
    $display("enable done");
  endtask
  task automatic t_sig();
    for (int i = 0; i < 4; i++) begin
      prog_u.xfer({SPD_OP_RD_SIG, 8'hFF, 6'h3F, i[1:0], 8'h00}, rd);
      chk(rd, sig[i]);
    end
    $display("signature done");
  endtask
  task automatic t_lock_erase();
    prog_u.xfer({SPD_OP_ENABLE, 8'hFD, 16'hFFFF}, rd);
    chk({6'h0, lock}, 8'h02);
    prog_u.xfer({SPD_OP_ENABLE, 8'hFB, 16'hFFFF}, rd);
    chk({6'h0, lock}, 8'h00);
    prog_u.xfer({SPD_OP_ENABLE, 8'h9F, 16'hFFFF}, rd);
    repeat (4200) @(negedge clk);
    chk({6'h0, lock}, 8'h03);
    prog_u.xfer({SPD_OP_RD_EE, 8'h01, 8'hFF, 8'h00}, rd);
    chk(rd, SPD_ERASED_BYTE);
    $display("lock and erase done");
  endtask
  task automatic t_ee();
    prog_u.xfer({SPD_OP_WR_EE, 8'hFF, 8'h5A, 8'h3C}, rd);
    prog_u.xfer({SPD_OP_RD_EE, 8'hFE, 8'h5A, 8'h00}, rd);
    chk(rd, SPD_ERASED_BYTE);
    prog_u.xfer({8'h50, 8'h01, 8'h5A, 8'h00}, rd);
    prog_u.xfer({SPD_OP_RD_EE, 8'h01, 8'h5A, 8'h00}, rd);
    chk(rd, 8'h3C);
    $display("data array done");
  endtask
  task automatic t_prog();
    prog_u.xfer({SPD_OP_WR_PROG | 8'h08, 8'hF3, 8'h21, 8'hA5}, rd);
    prog_u.xfer({SPD_OP_RD_PROG | 8'h08, 8'h53, 8'h21, 8'h00}, rd);
    chk(rd, 8'hA5);
    prog_u.xfer({SPD_OP_RD_PROG, 8'h03, 8'h21, 8'h00}, rd);
    chk(rd, SPD_ERASED_BYTE);
    prog_u.xfer({SPD_OP_WR_PROG, 8'hA3, 8'h21, 8'h5A}, rd);
    prog_u.xfer({SPD_OP_RD_PROG, 8'hC3, 8'h21, 8'h00}, rd);
    chk(rd, 8'h5A);
    prog_u.xfer({SPD_OP_RD_PROG | 8'h08, 8'h03, 8'h21, 8'h00}, rd);
    chk(rd, 8'hA5);
    @(negedge clk) pin_n <= 1'b1;
    repeat (10) @(negedge clk);
    chk({7'h0, on}, 8'h00);
    $display("program array done");
  endtask
  initial begin
    #1ms;
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (8) @(negedge clk);
    rst <= 1'b0;
    repeat (8) @(negedge clk);
    t_enable();
    t_sig();
    t_lock_erase();
    t_ee();
    t_prog();
    end_sim();
  end
endmodule
